// ==== include/pps_pkg.sv ====
// Purpose: Constants and types for the PWM protection sequencer
// Assumes: 50 MHz ref_clk; comparator flags are synchronous digital levels
// Notes:   Times are kept in their own units and turned into cycle counts here
//
// Overview of operation
// R1 - Gate switches at a fixed internal 65 kHz in normal mode.
// R2 - Each gate pulse ends by 75 percent of the switching period.
// R3 - Current-sense comparator ignored for 350 ns after each gate rising edge.
// R4 - Switching starts after supply turn-on flag, stops on supply turn-off flag.
// R5 - Unblanked current-limit comparator ends the pulse within the cycle.
// R6 - Brownout holds the gate off even when supply turn-on is met.
// R7 - After brownout clears, restart waits for the next supply turn-on event.
// R8 - Line-good uses hysteresis between turn-on and turn-off comparator flags.
// R9 - Over-voltage flag must persist 100 us before tripping protection.
// R10 - Overload flag held over 30 ms turns the gate drive off.
// R11 - Tripped over-voltage forces the gate off at once while it persists.
// R12 - Feedback below green threshold switches to the 20 kHz oscillator.
// R13 - Overload counter clears whenever the overload flag drops early.
// R14 - After a fault, stay off until supply turn-off, then restart on turn-on.
package pps_pkg;
    localparam int unsigned CLK_HZ        = 50_000_000;
    localparam int unsigned NORM_FREQ_HZ  = 65_000;
    localparam int unsigned GREEN_FREQ_HZ = 20_000;
    localparam int unsigned MAX_DUTY_PCT  = 75;
    localparam int unsigned BLANK_NS      = 350;
    localparam int unsigned OVP_DEB_US    = 100;
    localparam int unsigned OLP_DELAY_MS  = 30;
    localparam int unsigned CLK_PERIOD_NS = 20;

    localparam int unsigned CNT_W = 16;
    localparam int unsigned DLY_W = 24;

    // Period rounded down, duty limit rounded down, blank time rounded up
    localparam int unsigned NORM_PER  = CLK_HZ / NORM_FREQ_HZ;
    localparam int unsigned GREEN_PER = CLK_HZ / GREEN_FREQ_HZ;
    localparam int unsigned NORM_MAX  = NORM_PER * MAX_DUTY_PCT / 100;
    localparam int unsigned GREEN_MAX = GREEN_PER * MAX_DUTY_PCT / 100;
    localparam int unsigned BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned OVP_CYC   = OVP_DEB_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned OLP_CYC   = OLP_DELAY_MS * 1000 * (1000 / CLK_PERIOD_NS);

    typedef enum logic [1:0] {
        PPS_ST_LOCKOUT,
        PPS_ST_RUN,
        PPS_ST_FAULT
    } pps_state_t;

    typedef struct packed {
        logic supply_on;
        logic supply_off;
        logic line_on;
        logic line_off;
        logic cs_limit;
        logic fb_overload;
        logic fb_green;
        logic ovp_high;
    } pps_flags_t;

    typedef struct packed {
        logic gate;
        logic running;
        logic green_mode;
        logic line_good;
        logic overvoltage_guard;
        logic overload_guard;
    } pps_status_t;
endpackage

// ==== core/pps_core.sv ====
// Purpose: Gate pulse generator with supply, line, over-voltage and overload guards
// Assumes: All flags synchronous to ref_clk, active high
// Notes:   Gate output and status come straight from flip-flops
`timescale 1ns/1ps
module pps_core #(
    parameter int unsigned OVP_CYCLES = pps_pkg::OVP_CYC,
    parameter int unsigned OLP_CYCLES = pps_pkg::OLP_CYC
) (
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    input  wire pps_pkg::pps_flags_t flags,
    output pps_pkg::pps_status_t   status
);
    localparam int unsigned CW = pps_pkg::CNT_W;
    localparam int unsigned DW = pps_pkg::DLY_W;

    function automatic logic [CW-1:0] to_cnt(input int unsigned v);
        to_cnt = CW'(v);
    endfunction

    pps_pkg::pps_state_t state;
    pps_pkg::pps_state_t next_state;
    logic [CW-1:0] phase;
    logic [CW-1:0] blank_cnt;
    logic [DW-1:0] ovp_cnt;
    logic [DW-1:0] olp_cnt;
    logic          line_good;
    logic          ovp_trip;
    logic          olp_trip;
    logic          green;
    logic          gate;
    logic          running;
    logic          supply_on_d;

    // Oscillator selection
    wire           next_green   = pps_pkg::NORM_PER > 0 && flags.fb_green;      // [R12]
    wire [CW-1:0]  period_last  = green ? to_cnt(pps_pkg::GREEN_PER - 1)
                                        : to_cnt(pps_pkg::NORM_PER - 1);    // [R1] [R12]
    wire [CW-1:0]  duty_last    = green ? to_cnt(pps_pkg::GREEN_MAX)
                                        : to_cnt(pps_pkg::NORM_MAX);        // [R2]
    wire           cycle_end    = phase >= period_last;
    wire           blanked      = blank_cnt != '0;                           // [R3]
    wire           cs_hit       = flags.cs_limit && !blanked;                // [R3] [R5]
    wire           supply_rise  = flags.supply_on && !supply_on_d;           // [R4] [R7]

    // Line hysteresis: good on turn-on flag, lost only on turn-off flag
    wire next_line_good = flags.line_off ? 1'b0 :
                          flags.line_on  ? 1'b1 : line_good;                 // [R8]

    wire ovp_full    = ovp_cnt >= DW'(OVP_CYCLES - 1);
    wire next_ovp    = flags.ovp_high && ovp_full;                           // [R9] [R11]
    wire [DW-1:0] next_ovp_cnt = !flags.ovp_high ? '0 :
                                 ovp_full ? ovp_cnt : ovp_cnt + DW'(1);      // [R9]
    wire olp_full    = olp_cnt >= DW'(OLP_CYCLES);
    wire [DW-1:0] next_olp_cnt = !flags.fb_overload ? '0 :
                                 olp_full ? olp_cnt : olp_cnt + DW'(1);      // [R13]
    wire next_olp    = flags.fb_overload && olp_full;                        // [R10]

    wire fault_now   = next_ovp || next_olp;
    wire may_run     = state == pps_pkg::PPS_ST_RUN && !flags.supply_off
                       && line_good && !fault_now;                           // [R4] [R6] [R11]

    always_comb begin
        next_state = state;
        case (state)
            pps_pkg::PPS_ST_LOCKOUT: begin
                if (supply_rise && line_good && !fault_now) begin
                    next_state = pps_pkg::PPS_ST_RUN;                        // [R4] [R7] [R14]
                end
            end
            pps_pkg::PPS_ST_RUN: begin
                if (fault_now) begin
                    next_state = pps_pkg::PPS_ST_FAULT;                      // [R10] [R11]
                end else if (flags.supply_off || !line_good) begin
                    next_state = pps_pkg::PPS_ST_LOCKOUT;                    // [R4] [R6]
                end
            end
            pps_pkg::PPS_ST_FAULT: begin
                if (flags.supply_off) begin
                    next_state = pps_pkg::PPS_ST_LOCKOUT;                    // [R14]
                end
            end
            default: next_state = pps_pkg::PPS_ST_LOCKOUT;
        endcase
    end

    wire [CW-1:0] next_phase = (!may_run || cycle_end) ? '0 : phase + to_cnt(1);
    wire start_pulse = may_run && (state == pps_pkg::PPS_ST_RUN) && phase == '0;
    wire end_pulse   = cs_hit || phase >= duty_last || !may_run;             // [R2] [R5]
    wire next_gate   = start_pulse ? 1'b1 : (end_pulse ? 1'b0 : gate);
    wire [CW-1:0] next_blank = (start_pulse && !gate) ? to_cnt(pps_pkg::BLANK_CYC)
                             : (blanked ? blank_cnt - to_cnt(1) : '0);      // [R3]

    // Supervisor state
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state <= pps_pkg::PPS_ST_LOCKOUT;
        end else begin
            state <= next_state;
        end
    end

    // Run flag for the status port
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            running <= 1'b0;
        end else begin
            running <= next_state == pps_pkg::PPS_ST_RUN;
        end
    end

    // Oscillator phase
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            phase <= '0;
        end else begin
            phase <= next_phase;
        end
    end

    // Blanking countdown
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            blank_cnt <= '0;
        end else begin
            blank_cnt <= next_blank;
        end
    end

    // Over-voltage debounce counter
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ovp_cnt <= '0;
        end else begin
            ovp_cnt <= next_ovp_cnt;
        end
    end

    // Over-voltage trip flag
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ovp_trip <= 1'b0;
        end else begin
            ovp_trip <= next_ovp;
        end
    end

    // Overload delay counter
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            olp_cnt <= '0;
        end else begin
            olp_cnt <= next_olp_cnt;
        end
    end

    // Overload trip flag
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            olp_trip <= 1'b0;
        end else begin
            olp_trip <= next_olp;
        end
    end

    // Line-good latch
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            line_good <= 1'b0;
        end else begin
            line_good <= next_line_good;
        end
    end

    // Green choice taken whenever phase is zero: at period start, and every cycle while stopped
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            green <= 1'b0;
        end else begin
            green <= (phase == '0) ? next_green : green;
        end
    end

    // Gate drive
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            gate <= 1'b0;
        end else begin
            gate <= next_gate;
        end
    end

    // Supply turn-on edge detector, no false edge out of reset
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            supply_on_d <= 1'b1;
        end else begin
            supply_on_d <= flags.supply_on;
        end
    end

    // Status fields straight from the flops
    assign status.gate              = gate;
    assign status.running           = running;
    assign status.green_mode        = green;
    assign status.line_good         = line_good;
    assign status.overvoltage_guard = ovp_trip;
    assign status.overload_guard    = olp_trip;
endmodule

// ==== tb/pps_sense_model.sv ====
// Purpose: Current-sense comparator model facing the gate driver
// Assumes: Sensed current ramps only while the gate is high
// Notes:   trip_at of zero keeps the comparator quiet
`timescale 1ns/1ps
module pps_sense_model (
    input  wire logic        ref_clk,
    input  wire logic        gate,
    input  wire logic [15:0] trip_at,
    output logic             cs_limit
);
    logic [15:0] on_cnt;
    always_ff @(posedge ref_clk) begin
        on_cnt <= gate ? on_cnt + 16'h1 : 16'h0;
    end
    // Stays tripped until the gate turns off
    assign cs_limit = gate && trip_at != 16'h0 && on_cnt >= trip_at;
endmodule

// ==== tb/pps_core_monitor.sv ====
// Purpose: Port checks for pps_core
// Assumes: Guard delays handed on from the bound instance
// Notes:   Run counters track gate and fault flag lengths
`timescale 1ns/1ps
module pps_core_monitor #(
    parameter int unsigned OVP_CYCLES = 20,
    parameter int unsigned OLP_CYCLES = 50
) (
    input wire logic                 ref_clk,
    input wire logic                 sys_rst,
    input wire pps_pkg::pps_flags_t  flags,
    input wire pps_pkg::pps_status_t status
);
    logic [23:0] hi_n, ov_n, ol_n;
    always_ff @(posedge ref_clk) begin
        hi_n <= (status.gate && !sys_rst) ? hi_n + 24'h1 : 24'h0;
        ov_n <= (flags.ovp_high && !sys_rst) ? ov_n + 24'h1 : 24'h0;
        ol_n <= (flags.fb_overload && !sys_rst) ? ol_n + 24'h1 : 24'h0;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    a_duty_limit: assert property ($rose(status.gate) && !status.green_mode
        |-> ##[1:577] !status.gate) else $error("gate pulse over duty limit");
    a_blank_hold: assert property (status.gate && hi_n < 24'd16
        && !(flags.ovp_high || flags.fb_overload || flags.supply_off || flags.line_off)
        |=> status.gate) else $error("gate cut inside blanking");
    a_cs_ends: assert property (status.gate && flags.cs_limit && hi_n > 24'd20
        |-> ##[1:2] !status.gate) else $error("current limit ignored");
    a_ovp_debounce: assert property ($rose(status.overvoltage_guard)
        |-> ov_n >= OVP_CYCLES) else $error("over-voltage tripped early");
    a_ovp_gate_off: assert property (status.overvoltage_guard |-> !status.gate)
        else $error("gate on during over-voltage");
    a_olp_delay: assert property ($rose(status.overload_guard)
        |-> ol_n > OLP_CYCLES) else $error("overload tripped early");
    a_olp_gate_off: assert property (status.overload_guard |=> !status.gate)
        else $error("gate on during overload");
    a_brown_gate_off: assert property (!status.line_good [*2] |=> !status.gate)
        else $error("gate on during brownout");
    a_start_event: assert property ($rose(status.running)
        |-> $past(flags.supply_on) && status.line_good) else $error("bad start");
    c_ovp: cover property ($rose(status.overvoltage_guard));
    c_olp: cover property ($rose(status.overload_guard));
    c_cs: cover property (status.gate && flags.cs_limit && hi_n > 24'd20);
endmodule
bind pps_core pps_core_monitor #(.OVP_CYCLES(OVP_CYCLES), .OLP_CYCLES(OLP_CYCLES)) u_mon (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .flags(flags), .status(status));

// ==== tb/test_pwm_protection_sequencer.sv ====
// Purpose: Scenario bench for the PWM protection sequencer
// Assumes: Guard delays shortened to 20 and 50 cycles
// Notes:   Current limit comes from the sense model
`timescale 1ns/1ps
module test_pwm_protection_sequencer;
    logic                 ref_clk = 1'b0;
    logic                 sys_rst = 1'b1;
    logic [15:0]          trip_at = 16'h0;
    logic                 cs_w;
    int                   error_cnt = 0;
    int                   checks_done = 0;
    logic [31:0]          w, p;
    pps_pkg::pps_flags_t  fl = '0;
    pps_pkg::pps_flags_t  flags;
    pps_pkg::pps_status_t status;
    always_comb begin
        flags = fl;
        flags.cs_limit = cs_w;
    end
    initial forever #10 ref_clk = ~ref_clk;
    pps_core #(.OVP_CYCLES(20), .OLP_CYCLES(50)) DUT (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .flags(flags), .status(status));
    pps_sense_model u_sense (.ref_clk(ref_clk), .gate(status.gate), .trip_at(trip_at),
        .cs_limit(cs_w));
    task automatic wrap_up;
        if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Gate high length and rise-to-rise time of the next pulse
    task automatic pulse;
        int i;
        w = 0;
        p = 0;
        for (i = 0; i < 6000 && status.gate !== 1'b0; i++) cyc(1);
        for (i = 0; i < 6000 && status.gate !== 1'b1; i++) cyc(1);
        while (status.gate === 1'b1 && w < 6000) begin w++; p++; cyc(1); end
        while (status.gate !== 1'b1 && p < 6000) begin p++; cyc(1); end
        if (p >= 6000) begin chk("pulse wait", 0, 1); wrap_up(); end
    endtask
    task automatic recover;
        fl.supply_off <= 1'b1; fl.supply_on <= 1'b0; cyc(4);
        chk("stopped", 0, status.running);
        fl.supply_off <= 1'b0; cyc(3); fl.supply_on <= 1'b1; cyc(5);
        chk("restarted", 1, status.running);
    endtask
    task automatic t_lockout;
        cyc(4); chk("idle gate", 0, status.gate);
        fl.line_on <= 1'b1; cyc(2); fl.line_on <= 1'b0; fl.supply_on <= 1'b1; cyc(6);
        chk("line hysteresis", 1, status.line_good);
    endtask
    task automatic t_pulse;
        pulse(); chk("period", 769, p); chk("duty cap", 1, w >= 560 && w <= 577);
        fl.fb_green <= 1'b1; pulse(); pulse(); chk("green period", 2500, p);
        chk("green flag", 1, status.green_mode);
        fl.fb_green <= 1'b0; pulse();
    endtask
    task automatic t_cs;
        trip_at <= 16'd5; pulse(); chk("blanked", 1, w >= 18 && w <= 21);
        trip_at <= 16'd40; pulse(); chk("cs end", 1, w >= 40 && w <= 44);
        trip_at <= 16'h0; recover();
    endtask
    task automatic t_ovp;
        fl.ovp_high <= 1'b1; cyc(10); fl.ovp_high <= 1'b0; cyc(2);
        chk("ovp glitch", 0, status.overvoltage_guard);
        fl.ovp_high <= 1'b1; cyc(25); chk("ovp trip", 1, status.overvoltage_guard);
        chk("ovp gate", 0, status.gate);
        fl.ovp_high <= 1'b0; cyc(800); chk("ovp hold", 0, status.gate); recover();
    endtask
    task automatic t_olp;
        fl.fb_overload <= 1'b1; cyc(40); fl.fb_overload <= 1'b0; cyc(1);
        fl.fb_overload <= 1'b1; cyc(40); chk("olp clear", 0, status.overload_guard);
        cyc(20); chk("olp trip", 1, status.overload_guard);
        chk("olp gate", 0, status.gate); fl.fb_overload <= 1'b0; recover();
    endtask
    task automatic t_brown;
        fl.line_off <= 1'b1; cyc(4); chk("brown gate", 0, status.gate);
        fl.line_off <= 1'b0; fl.line_on <= 1'b1; cyc(800);
        chk("brown wait", 0, status.running); recover();
    endtask
    initial begin
        cyc(8); sys_rst <= 1'b0;
        t_lockout(); t_pulse(); t_cs(); t_ovp(); t_olp(); t_brown();
        wrap_up();
    end
endmodule
